// ===== logic/lmid_defs.svh
`ifndef LMID_DEFS_SVH
`define LMID_DEFS_SVH

// register offsets (byte addresses, one aligned word each)
`define LMID_OFF_EVENT     8'h00
`define LMID_OFF_STATUS    8'h04
`define LMID_OFF_FLAGS     8'h08
`define LMID_OFF_IP        8'h0c
`define LMID_OFF_CS        8'h10
`define LMID_OFF_STACK     8'h14
`define LMID_OFF_TBL_BASE  8'h18
`define LMID_OFF_TBL_LIMIT 8'h1c
`define LMID_OFF_TASK32    8'h20
`define LMID_OFF_TASK16    8'h24
`define LMID_OFF_INTERRUPT_RETURN_INSTR      8'h28
`define LMID_OFF_SEGLOAD   8'h2c
`define LMID_OFF_CTRL      8'h30

// processor flag bit positions
`define LMID_FLAG_TF 8
`define LMID_FLAG_IF 9
`define LMID_FLAG_RC 16
`define LMID_FLAG_VM 17
`define LMID_FLAG_AC 18

// event register fields
`define LMID_EVT_MASKABLE 8

// status register fields
`define LMID_ST_BUSY     0
`define LMID_ST_REFUSED  1
`define LMID_ST_VM       2
`define LMID_ST_REAL     3
`define LMID_ST_CPL_LO   4
`define LMID_ST_OVERRUN  6
`define LMID_ST_SEG_PROT 7

// reset values
`define LMID_TBL_BASE_RST  32'h0000_0000
`define LMID_TBL_LIMIT_RST 16'h03ff
`define LMID_FLAGS_RST     32'h0000_0002
`define LMID_CS_RST        16'h0000
`define LMID_IP_RST        16'h0000
`define LMID_SS_RST        16'h0000
`define LMID_SP_RST        16'h0000

// vectors with a mode-dependent meaning, then reserved vectors refused in every mode
`define LMID_VEC_TS  8'h0a
`define LMID_VEC_NP  8'h0b
`define LMID_VEC_GP  8'h0d
`define LMID_VEC_PF  8'h0e
`define LMID_VEC_AC  8'h11
`define LMID_VEC_R9  8'h09
`define LMID_VEC_R15 8'h0f
`define LMID_VEC_R19 8'h13
`define LMID_VEC_R31 8'h1f

// geometry
`define LMID_ENTRY_SHIFT 2
`define LMID_SEG_SHIFT   4
`define LMID_WORD_BYTES  16'h0002
`define LMID_CPL_VM      2'h3

`endif

// ===== logic/lmid_dispatch.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`include "lmid_defs.svh"
// Overview of operation
// [RULE1] vector number indexes the handler table
// [RULE2] entry is offset word then selector
// [RULE3] push code segment, then low ip
// [RULE4] then push low 16 flag bits
// [RULE5] then clear maskable interrupt enable
// [RULE6] also clear trap, resume, alignment flags
// [RULE7] finally load handler selector and offset
// [RULE8] return pops ip, segment, flags back
// [RULE9] no error code pushed in real mode
// [RULE10] entry offset is vector times four
// [RULE11] reset: table base 0, limit 3ff
// [RULE12] table base and limit are rewritable
// [RULE13] software should keep table defaults
// [RULE14] vectors 10,11,14,17 refused in real mode
// [RULE15] vector 13 means overrun in real mode
// [RULE16] virtual mode follows virtual machine flag
// [RULE17] flag pops never change virtual flag
// [RULE18] virtual mode runs at privilege three
// [RULE19] segment load checks virtual flag
// [RULE20] decoder checks use virtual flag
// [RULE21] small task switch drops upper flags
// [RULE22] legacy base is selector shifted four
module lmid_dispatch
    import lmid_pkg::*;
#(
    parameter int ADDR_W = 8                   // apb address width
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic                   mem_req_out,
    output logic                   mem_we_out,
    output logic      [31:0]       mem_addr_out,
    output logic      [15:0]       mem_wdata_out,
    input  wire logic              mem_ack_in,
    input  wire logic [15:0]       mem_rdata_in,
    output logic                   busy_out,
    output logic                   vm_mode_out,
    output logic      [1:0]        cpl_out,
    output logic                   io_privilege_level_check_out,
    output logic                   io_io_privilege_level_check_out,
    output logic                   vec13_overrun_out,
    output logic                   pm_dispatch_out,
    output logic      [7:0]        pm_vector_out
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check
    // offsets reach 0x30, and the decode widens the address to one byte
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
        $error("lmid_dispatch: ADDR_W must be 6..8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0]  rst_sync_q;                   // two-stage release
    logic        rst_n;                        // synchronised reset, active low

    // async assert, clocked release
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'h0;
        end else if (ce_in) begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // legacy linear address: selector shifted plus offset, no 20-bit wrap
    function automatic logic [31:0] legacy_linear(input logic [15:0] seg,
                                                  input logic [15:0] off);
        legacy_linear = {12'h000, seg, 4'h0} + {16'h0000, off}; // RULE22
    endfunction

    // whether a vector may be raised in the given mode
    function automatic logic vector_legal(input logic [7:0] v, input logic real_m);
        logic rsv;
        rsv = (v == `LMID_VEC_R9) || (v == `LMID_VEC_R15) ||
              (v >= `LMID_VEC_R19 && v <= `LMID_VEC_R31);
        if (real_m) begin
            // protected-only faults never come from real mode
            vector_legal = !rsv && v != `LMID_VEC_TS && v != `LMID_VEC_NP &&
                           v != `LMID_VEC_PF && v != `LMID_VEC_AC; // RULE14
        end else begin
            vector_legal = !rsv;
        end
    endfunction

    // decode of mapped offsets
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a[1:0] == 2'h0) && ({{(8-ADDR_W){1'b0}}, a} <= `LMID_OFF_CTRL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    lmid_state_s s_q;                          // registered state
    lmid_state_s s_d;                          // next state
    logic        vm;                           // virtual legacy mode
    logic        real_m;                       // legacy real mode
    logic        ack;                          // memory step completes
    logic        wr_acc;                       // apb write taken this edge
    logic [7:0]  a8;                           // address widened to a byte
    logic [15:0] sp_dn;                        // stack pointer after a push
    logic [15:0] ent_hi;                       // last byte of table entry

    assign vm     = s_q.flags[`LMID_FLAG_VM]; // RULE16
    assign real_m = !s_q.pe && !vm;
    assign ack    = s_q.mem_req && mem_ack_in;
    assign wr_acc = psel_in && penable_in && pwrite_in && ce_in;
    assign a8     = {{(8-ADDR_W){1'b0}}, paddr_in};
    assign sp_dn  = s_q.sp - `LMID_WORD_BYTES;
    assign ent_hi = {6'h00, pwdata_in[7:0], 2'h3}; // RULE10

    // next-state logic: apb decode, register writes, dispatch sequencer
    always_comb begin
        s_d         = s_q;
        s_d.pm_disp = 1'b0;

        // read data captured in the setup cycle, answered in the access cycle
        if (psel_in && !penable_in) begin
            s_d.pslverr = !addr_mapped(paddr_in);
            unique case (a8)
                `LMID_OFF_EVENT:     s_d.prdata = {24'h0, s_q.vec};
                `LMID_OFF_STATUS:    s_d.prdata = {24'h0, s_q.seg_prot, s_q.overrun13,
                                                   cpl_out, real_m, vm, s_q.refused,
                                                   s_q.st != LMID_IDLE};
                `LMID_OFF_FLAGS:     s_d.prdata = s_q.flags;
                `LMID_OFF_IP:        s_d.prdata = {16'h0, s_q.ip};
                `LMID_OFF_CS:        s_d.prdata = {16'h0, s_q.cs};
                `LMID_OFF_STACK:     s_d.prdata = {s_q.ss, s_q.sp};
                `LMID_OFF_TBL_BASE:  s_d.prdata = s_q.tbl_base;
                `LMID_OFF_TBL_LIMIT: s_d.prdata = {16'h0, s_q.tbl_limit};
                `LMID_OFF_SEGLOAD:   s_d.prdata = s_q.seg_base;
                `LMID_OFF_CTRL:      s_d.prdata = {29'h0, s_q.current_privilege_level, s_q.pe};
                default:             s_d.prdata = 32'h0000_0000;
            endcase
        end

        unique case (s_q.st)
            // idle: all work starts from a register write
            LMID_IDLE: begin
            end
            // push code segment first
            LMID_C_CS: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req   = 1'b1;
                    s_d.mem_we    = 1'b1;
                    s_d.sp        = sp_dn;
                    s_d.mem_addr  = legacy_linear(s_q.ss, sp_dn);
                    s_d.mem_wdata = s_q.cs; // RULE3
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.st      = LMID_C_IP;
                end
            end
            // then the low half of the instruction pointer
            LMID_C_IP: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req   = 1'b1;
                    s_d.sp        = sp_dn;
                    s_d.mem_addr  = legacy_linear(s_q.ss, sp_dn);
                    s_d.mem_wdata = s_q.ip; // RULE3
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.st      = LMID_C_FL;
                end
            end
            // then the low flag word; no error code follows it
            LMID_C_FL: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req   = 1'b1;
                    s_d.sp        = sp_dn;
                    s_d.mem_addr  = legacy_linear(s_q.ss, sp_dn);
                    s_d.mem_wdata = s_q.flags[15:0]; // RULE4
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.flags[`LMID_FLAG_IF] = 1'b0; // RULE5
                    s_d.flags[`LMID_FLAG_TF] = 1'b0; // RULE6
                    s_d.flags[`LMID_FLAG_RC] = 1'b0; // RULE6
                    s_d.flags[`LMID_FLAG_AC] = 1'b0; // RULE6
                    s_d.st = LMID_C_OFF; // RULE9
                end
            end
            // fetch handler offset from the entry
            LMID_C_OFF: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_we   = 1'b0;
                    s_d.mem_addr = s_q.tbl_base +
                                   {22'h0, s_q.vec, 2'h0}; // RULE1 RULE10
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.tmp     = mem_rdata_in; // RULE2
                    s_d.st      = LMID_C_SEL;
                end
            end
            // fetch selector, then jump to the handler
            LMID_C_SEL: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_addr = s_q.mem_addr + {16'h0, `LMID_WORD_BYTES}; // RULE2
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.cs      = mem_rdata_in; // RULE7
                    s_d.ip      = s_q.tmp; // RULE7
                    s_d.st      = LMID_IDLE;
                end
            end
            // then pop instruction pointer, pushed second
            LMID_R_IP: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_we   = 1'b0;
                    s_d.mem_addr = legacy_linear(s_q.ss, s_q.sp);
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.sp      = s_q.sp + `LMID_WORD_BYTES;
                    s_d.tmp     = mem_rdata_in; // RULE8
                    s_d.st      = LMID_R_CS;
                end
            end
            // pop code segment
            LMID_R_CS: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_addr = legacy_linear(s_q.ss, s_q.sp);
                end else if (ack) begin
                    s_d.mem_req = 1'b0;
                    s_d.sp      = s_q.sp + `LMID_WORD_BYTES;
                    s_d.cs      = mem_rdata_in; // RULE8
                    s_d.ip      = s_q.tmp;
                    s_d.st      = LMID_IDLE;
                end
            end
            // return starts here: flags were pushed last, so they sit on top;
            // only the low word comes back, so the virtual flag stays
            LMID_R_FL: begin
                if (!s_q.mem_req) begin
                    s_d.mem_req  = 1'b1;
                    s_d.mem_we   = 1'b0;
                    s_d.mem_addr = legacy_linear(s_q.ss, s_q.sp);
                end else if (ack) begin
                    s_d.mem_req     = 1'b0;
                    s_d.sp          = s_q.sp + `LMID_WORD_BYTES;
                    s_d.flags[15:0] = mem_rdata_in; // RULE8
                    s_d.st          = LMID_R_IP;
                end
            end
            // illegal code: recover to idle
            default: begin
                s_d.mem_req = 1'b0;
                s_d.st      = LMID_IDLE;
            end
        endcase

        // register writes; ignored while a sequence runs so the stack stays sane
        if (wr_acc && s_q.st != LMID_IDLE) begin
            s_d.refused = 1'b1;
        end else if (wr_acc) begin
            unique case (a8)
                // raise an event with the given vector
                `LMID_OFF_EVENT: begin
                    s_d.vec       = pwdata_in[7:0];
                    s_d.overrun13 = real_m && pwdata_in[7:0] == `LMID_VEC_GP; // RULE15
                    if (!vector_legal(pwdata_in[7:0], real_m) ||
                        (pwdata_in[`LMID_EVT_MASKABLE] &&
                         !s_q.flags[`LMID_FLAG_IF])) begin
                        s_d.refused = 1'b1; // RULE14
                    end else if (!real_m) begin
                        // protected and virtual dispatch is handled elsewhere
                        s_d.refused = 1'b0;
                        s_d.pm_disp = 1'b1;
                    end else if (ent_hi > s_q.tbl_limit) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.refused = 1'b0;
                        s_d.st      = LMID_C_CS; // RULE1
                    end
                end
                // flag writes act as a flag pop: virtual flag untouched
                `LMID_OFF_FLAGS: begin
                    s_d.flags = pwdata_in;
                    s_d.flags[`LMID_FLAG_VM] = s_q.flags[`LMID_FLAG_VM]; // RULE17
                end
                `LMID_OFF_IP:        s_d.ip = pwdata_in[15:0];
                `LMID_OFF_CS:        s_d.cs = pwdata_in[15:0];
                `LMID_OFF_STACK: begin
                    s_d.ss = pwdata_in[31:16];
                    s_d.sp = pwdata_in[15:0];
                end
                `LMID_OFF_TBL_BASE:  s_d.tbl_base  = pwdata_in; // RULE12
                `LMID_OFF_TBL_LIMIT: s_d.tbl_limit = pwdata_in[15:0]; // RULE12
                // task switches exist only with protection on
                `LMID_OFF_TASK32: begin
                    s_d.refused = !s_q.pe;
                    if (s_q.pe) begin
                        s_d.flags = pwdata_in; // RULE17
                    end
                end
                `LMID_OFF_TASK16: begin
                    s_d.refused = !s_q.pe;
                    if (s_q.pe) begin
                        s_d.flags = {16'h0000, pwdata_in[15:0]}; // RULE21
                    end
                end
                // real mode unwinds the stack; protected return takes the image
                `LMID_OFF_INTERRUPT_RETURN_INSTR: begin
                    s_d.refused = vm;
                    if (real_m) begin
                        s_d.st = LMID_R_FL; // RULE8
                    end else if (!vm) begin
                        s_d.flags = pwdata_in; // RULE17
                    end
                end
                // segment load: legacy base or protected selector
                `LMID_OFF_SEGLOAD: begin
                    s_d.seg_prot = !real_m && !vm; // RULE19
                    s_d.seg_base = (real_m || vm) ?
                                   legacy_linear(pwdata_in[15:0], 16'h0000) :
                                   32'h0000_0000;
                end
                `LMID_OFF_CTRL: begin
                    s_d.pe  = pwdata_in[0];
                    s_d.current_privilege_level = pwdata_in[2:1];
                end
                // status, unmapped: no effect
                default: begin
                end
            endcase
        end
    end

    // single state register, frozen while clock enable is low
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.st        <= LMID_IDLE;
            s_q.flags     <= `LMID_FLAGS_RST;
            s_q.cs        <= `LMID_CS_RST;
            s_q.ip        <= `LMID_IP_RST;
            s_q.ss        <= `LMID_SS_RST;
            s_q.sp        <= `LMID_SP_RST;
            s_q.tbl_base  <= `LMID_TBL_BASE_RST; // RULE11
            s_q.tbl_limit <= `LMID_TBL_LIMIT_RST; // RULE11
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata_out        = s_q.prdata;
    assign pready_out        = psel_in && penable_in && ce_in;
    assign pslverr_out       = pready_out && s_q.pslverr;
    assign mem_req_out       = s_q.mem_req;
    assign mem_we_out        = s_q.mem_we;
    assign mem_addr_out      = s_q.mem_addr;
    assign mem_wdata_out     = s_q.mem_wdata;
    assign busy_out          = s_q.st != LMID_IDLE;
    assign vm_mode_out       = vm;
    assign cpl_out           = vm ? `LMID_CPL_VM : (s_q.pe ? s_q.current_privilege_level : 2'h0); // RULE18
    assign io_privilege_level_check_out    = vm; // RULE20
    assign io_io_privilege_level_check_out = s_q.pe && !vm; // RULE20
    assign vec13_overrun_out = s_q.overrun13;
    assign pm_dispatch_out   = s_q.pm_disp;
    assign pm_vector_out     = s_q.vec;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    chk_push_order: assert property (ce_in && ack && s_q.st == LMID_C_CS |=> // RULE3
        s_q.st == LMID_C_IP && !mem_req_out ##1 mem_wdata_out == s_q.ip)
        else $error("ip push does not follow segment push");
    chk_flag_push: assert property (s_q.st == LMID_C_FL && mem_req_out |-> // RULE4
        mem_we_out && mem_wdata_out == s_q.flags[15:0])
        else $error("flag push carries wrong word");
    chk_if_clear: assert property (ce_in && ack && s_q.st == LMID_C_FL |=> // RULE5
        !s_q.flags[`LMID_FLAG_IF])
        else $error("interrupt enable left set");
    chk_trap_clear: assert property (ce_in && ack && s_q.st == LMID_C_FL |=> // RULE6
        !s_q.flags[`LMID_FLAG_TF] && !s_q.flags[`LMID_FLAG_RC] &&
        !s_q.flags[`LMID_FLAG_AC])
        else $error("trap, resume or alignment flag left set");
    chk_no_errcode: assert property (ce_in && ack && s_q.st == LMID_C_FL |=> // RULE9
        s_q.st == LMID_C_OFF)
        else $error("extra push after flags");
    chk_table_addr: assert property (s_q.st == LMID_C_OFF && mem_req_out |-> // RULE10
        mem_addr_out == s_q.tbl_base + {22'h0, s_q.vec, 2'h0})
        else $error("table entry address wrong");
    chk_handler_load: assert property (ce_in && ack && s_q.st == LMID_C_SEL |=> // RULE7
        s_q.cs == $past(mem_rdata_in) && s_q.ip == $past(s_q.tmp) && !busy_out)
        else $error("handler not loaded");
    chk_vm_cpl: assert property (vm_mode_out |-> cpl_out == 2'h3) // RULE18
        else $error("virtual mode not at privilege three");
    chk_vm_pop: assert property (wr_acc && a8 == `LMID_OFF_FLAGS |=> // RULE17
        vm_mode_out == $past(vm_mode_out))
        else $error("flag pop changed virtual flag");
    chk_reset_tbl: assert property ($rose(rst_n) |-> // RULE11
        s_q.tbl_base == 32'h0 && s_q.tbl_limit == 16'h03ff)
        else $error("table defaults wrong after reset");
    chk_real_vec: assert property (wr_acc && !busy_out && real_m && a8 == `LMID_OFF_EVENT &&
        pwdata_in[7:0] == 8'h0e |=> s_q.refused && !busy_out) // RULE14
        else $error("page fault vector dispatched in real mode");

endmodule // lmid_dispatch

// ===== logic/lmid_pkg.sv
package lmid_pkg;

    // dispatch sequencer, one-hot
    typedef enum logic [8:0] {
        LMID_IDLE  = 9'h001,
        LMID_C_CS  = 9'h002,
        LMID_C_IP  = 9'h004,
        LMID_C_FL  = 9'h008,
        LMID_C_OFF = 9'h010,
        LMID_C_SEL = 9'h020,
        LMID_R_IP  = 9'h040,
        LMID_R_CS  = 9'h080,
        LMID_R_FL  = 9'h100
    } lmid_state_e;

    // whole state of the dispatch unit
    typedef struct packed {
        lmid_state_e st;
        logic [31:0] flags;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [15:0] ss;
        logic [15:0] sp;
        logic [31:0] tbl_base;
        logic [15:0] tbl_limit;
        logic [7:0]  vec;
        logic        pe;
        logic [1:0]  current_privilege_level;
        logic        refused;
        logic        overrun13;
        logic [31:0] seg_base;
        logic        seg_prot;
        logic [15:0] tmp;
        logic        mem_req;
        logic        mem_we;
        logic [31:0] mem_addr;
        logic [15:0] mem_wdata;
        logic [31:0] prdata;
        logic        pslverr;
        logic        pm_disp;
    } lmid_state_s;

endpackage

// ===== testbench/lmid_mem_model.sv
`timescale 1ns/1ns
// stack and handler table memory, answers on alternate cycles
module lmid_mem_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [15:0] wdata_in,
    output logic             ack_out,
    output logic [15:0]      rdata_out
);
    logic [15:0] mem_q [0:255]; // word store, index is addr bits 8:1
    logic        slow_q = 1'b0; // toggles so answers come prompt or late
    initial ack_out = 1'b0;
    initial rdata_out = 16'h0000;
    ////////////////////////////////////////////////////////////////
    // answer one cycle, data stays valid only with ack
    always @(posedge clk_in) begin
        slow_q <= ~slow_q;
        ack_out <= req_in & ~ack_out & slow_q;
        rdata_out <= (req_in & ~ack_out & slow_q) ? mem_q[addr_in[8:1]] : ~rdata_out;
        if (req_in & ack_out & we_in) begin
            mem_q[addr_in[8:1]] <= wdata_in;
        end
    end
endmodule // lmid_mem_model

// ===== testbench/lmid_tb.sv
`timescale 1ns/1ns
`include "lmid_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00, pmv, pm_seen = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, mreq, mwe, mack, busy, vm, io_privilege_level, io, vo, pmd;
    logic [31:0] maddr;
    logic [15:0] mwd, mrd;
    logic [1:0]  current_privilege_level;
    int          mismatches = 0, cmp_count = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    lmid_dispatch i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd),
        .mem_ack_in(mack), .mem_rdata_in(mrd), .busy_out(busy), .vm_mode_out(vm),
        .cpl_out(current_privilege_level), .io_privilege_level_check_out(io_privilege_level), .io_io_privilege_level_check_out(io), .vec13_overrun_out(vo),
        .pm_dispatch_out(pmd), .pm_vector_out(pmv));
    // keep the vector of the last hand-off pulse
    always @(posedge clk) if (pmd) pm_seen <= pmv;
    lmid_mem_model i_mem (.clk_in(clk), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
        .wdata_in(mwd), .ack_out(mack), .rdata_out(mrd));
    ////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n == 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // wait for a dispatch or return sequence to finish, bounded
    task automatic wb();
        int n;
        n = 0;
        do @(negedge clk); while (busy !== 1'b0 && ++n < 200);
        if (n == 200) mismatches++;
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, whole run needs well under this
    always @(posedge clk) if (++cyc == 4000) begin mismatches++; stop_test(); end
    initial begin
        i_mem.mem_q[8'h40] = 16'haa00;
        i_mem.mem_q[8'h41] = 16'h0bb0;
        i_mem.mem_q[8'hc0] = 16'hc0c0;
        i_mem.mem_q[8'hc1] = 16'hc1c1;
        i_mem.mem_q[8'h1a] = 16'h0d0d;
        i_mem.mem_q[8'h1b] = 16'h1b1b;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, `LMID_OFF_TBL_BASE, 0);  `CHK(rd, 32'h0)
        apb(0, `LMID_OFF_TBL_LIMIT, 0); `CHK(rd, 32'h3ff)
        apb(0, 8'h34, 0);               `CHK(err, 1'b1)
        // table defaults kept for the first dispatch
        apb(1, `LMID_OFF_STACK, 32'h200);
        apb(1, `LMID_OFF_FLAGS, 32'h50302);
        apb(1, `LMID_OFF_IP, 32'h1234);
        apb(1, `LMID_OFF_CS, 32'h5678);
        apb(1, `LMID_OFF_EVENT, 32'h120);
        wb();
        `CHK(i_mem.mem_q[8'hff], 16'h5678)
        `CHK(i_mem.mem_q[8'hfe], 16'h1234)
        `CHK(i_mem.mem_q[8'hfd], 16'h0302)
        apb(0, `LMID_OFF_FLAGS, 0); `CHK(rd, 32'h2)
        apb(0, `LMID_OFF_IP, 0);    `CHK(rd, 32'haa00)
        apb(0, `LMID_OFF_CS, 0);    `CHK(rd, 32'h0bb0)
        apb(0, `LMID_OFF_STACK, 0); `CHK(rd, 32'h1fa)
        apb(1, `LMID_OFF_INTERRUPT_RETURN_INSTR, 0);
        wb();
        apb(0, `LMID_OFF_IP, 0);    `CHK(rd, 32'h1234)
        apb(0, `LMID_OFF_CS, 0);    `CHK(rd, 32'h5678)
        apb(0, `LMID_OFF_FLAGS, 0); `CHK(rd, 32'h302)
        apb(0, `LMID_OFF_STACK, 0); `CHK(rd, 32'h200)
        for (int i = 0; i < 4; i++) begin
            apb(1, `LMID_OFF_EVENT, {24'h0, i[1] ? (i[0] ? 8'h11 : 8'h0e) : (8'h0a | i[7:0])});
            apb(0, `LMID_OFF_STATUS, 0); `CHK(rd[1], 1'b1)
        end
        apb(1, `LMID_OFF_EVENT, 32'h0d);
        wb();
        apb(0, `LMID_OFF_STATUS, 0); `CHK({rd[6], vo}, 2'b11)
        apb(0, `LMID_OFF_IP, 0); `CHK(rd, 32'h0d0d)
        apb(1, `LMID_OFF_TBL_BASE, 32'h100);
        apb(1, `LMID_OFF_EVENT, 32'h20);
        wb();
        apb(0, `LMID_OFF_IP, 0); `CHK(rd, 32'hc0c0)
        apb(1, `LMID_OFF_CTRL, 32'h1);
        apb(1, `LMID_OFF_TASK32, 32'h20000);
        `CHK({vm, current_privilege_level, io_privilege_level, io}, 5'h1e)
        apb(1, `LMID_OFF_FLAGS, 0); `CHK(vm, 1'b1)
        apb(1, `LMID_OFF_SEGLOAD, 32'h1234);
        apb(0, `LMID_OFF_SEGLOAD, 0); `CHK(rd, 32'h12340)
        apb(1, `LMID_OFF_EVENT, 32'h0e);
        apb(0, `LMID_OFF_STATUS, 0); `CHK(rd[1], 1'b0)
        `CHK(pm_seen, 8'h0e)
        apb(1, `LMID_OFF_TASK16, 32'hffff);
        `CHK(vm, 1'b0)
        `CHK(io, 1'b1)
        stop_test();
    end
endmodule // tb
